// ==== adi_pkg.sv ====
/*
 * Package for the converter IO interface: instruction field layout,
 * transfer and control codes, register widths, reset values and carriers.
 * Assumes bus bits are numbered 0 (most significant) to 15 (least).
 */
package adi_pkg;

    // ------------------------------------------------------------------
    // Instruction layout (vector index = 15 - bus bit number)
    // ------------------------------------------------------------------
    localparam int          WORD_W        = 16;
    localparam logic [2:0]  IO_CLASS      = 3'h3;
    localparam logic [5:0]  CONV_DEV_CODE = 6'h11;

    typedef struct packed {
        logic [2:0] ioClass;   // bits 0-2
        logic [1:0] accSel;    // bits 3-4
        logic [2:0] xfer;      // bits 5-7
        logic [1:0] func;      // bits 8-9
        logic [5:0] devCode;   // bits 10-15
    } adi_instr_t;

    // Transfer codes
    localparam logic [2:0] XF_NIO     = 3'h0;
    localparam logic [2:0] XF_RD_CHAN = 3'h1;   // read_channel_instr
    localparam logic [2:0] XF_LD_CHAN = 3'h2;   // load_channel_instr
    localparam logic [2:0] XF_RD_ADDR = 3'h3;   // read_address_instr
    localparam logic [2:0] XF_LD_ADDR = 3'h4;   // load_address_instr
    localparam logic [2:0] XF_RD_SAMP = 3'h5;   // read_sample_instr
    localparam logic [2:0] XF_LD_CNT  = 3'h6;   // load_count_instr
    localparam logic [2:0] XF_SKP     = 3'h7;

    // Flag control actions
    localparam logic [1:0] F_NONE  = 2'h0;
    localparam logic [1:0] F_START = 2'h1;
    localparam logic [1:0] F_CLEAR = 2'h2;
    localparam logic [1:0] F_PULSE = 2'h3;

    // Flag tests on the skip transfer
    localparam logic [1:0] SK_BUSY_SET  = 2'h0;
    localparam logic [1:0] SK_BUSY_ZERO = 2'h1;
    localparam logic [1:0] SK_DONE_SET  = 2'h2;
    localparam logic [1:0] SK_DONE_ZERO = 2'h3;

    // ------------------------------------------------------------------
    // Register widths, positions and reset values
    // ------------------------------------------------------------------
    localparam int          CHAN_W        = 8;
    localparam int          ADDR_W        = 15;
    localparam int          COUNT_W       = 12;
    localparam int          MASK_BIT_IDX  = 7;    // bus bit 8
    localparam logic [7:0]  CHAN_RST      = 8'h00;
    localparam logic [7:0]  CHAN_ONE      = 8'h01;
    localparam logic [14:0] ADDR_RST      = 15'h0000;
    localparam logic [14:0] ADDR_ONE      = 15'h0001;
    localparam logic [11:0] COUNT_RST     = 12'h000;
    localparam logic [11:0] COUNT_ONE     = 12'h001;
    localparam logic [15:0] WORD_RST      = 16'h0000;

    localparam int          FIFO_DEPTH    = 32;

    // Word handed to the data channel
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } adi_dch_word_t;

endpackage : adi_pkg

// ==== adi_converter_if.sv ====
/*
 * Converter IO interface: instruction decode, busy/done flags, channel
 * scan, sample return and the data channel block engine with its FIFO.
 * Assumes one-cycle instruction strobes synchronous to core_clk and a
 * converter that answers each start pulse with one done pulse.
 */

// ----------------------------------------------------------------------
// FIFO between the converter and the data channel
// ----------------------------------------------------------------------
module adi_fifo #(
    parameter int WIDTH = 31,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0]   CNT_ZERO = '0;
    localparam logic [AW:0]   CNT_ONE  = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE  = AW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW-1:0]    rdPtr_d;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push    = inValid && inReady;
    assign pop     = outValid && outReady;
    assign rdPtr_d = pop ? rdPtr_q + PTR_ONE : rdPtr_q;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + CNT_ONE;
        end else if (pop && !push) begin
            count_d = count_q - CNT_ONE;
        end
    end

    // Head is registered so the word leaves the block straight from a flop
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
        if (push && (wrPtr_q == rdPtr_d)) begin
            outData <= inData;
        end else begin
            outData <= mem[rdPtr_d];
        end
    end

    // Flags are registered so full and empty never glitch on the pointers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wrPtr_q  <= '0;
            rdPtr_q  <= '0;
            count_q  <= '0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + PTR_ONE;
            end
            rdPtr_q <= rdPtr_d;
            count_q  <= count_d;
            inReady  <= (count_d != CNT_FULL);
            outValid <= (count_d != CNT_ZERO);
        end
    end
endmodule : adi_fifo

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module adi_converter_if
    import adi_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              ioStrobe,
    input  wire adi_instr_t        ioInstr,
    input  wire logic [WORD_W-1:0] accIn,
    input  wire logic              maskStrobe,
    input  wire logic              extendedEnable,
    input  wire logic              convDone,
    input  wire logic [WORD_W-1:0] convData,
    input  wire logic              dchAck,
    output logic      [WORD_W-1:0] rdData,
    output logic                   rdValid,
    output logic      [1:0]        rdAcc,
    output logic                   skipTaken,
    output logic                   busy,
    output logic                   done,
    output logic                   intReq,
    output logic                   convStart,
    output logic      [CHAN_W-1:0] channelSel,
    output logic                   dchReq,
    output adi_dch_word_t          dchWord
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic               hit;
    logic               flagOp;
    logic               actStart;
    logic               actClear;
    logic               actPulse;
    logic               convEnd;
    logic               wordStored;
    logic               lastWord;
    logic               setBusy;
    logic [COUNT_W-1:0] countInc;
    logic [CHAN_W-1:0]  chanNext;

    logic [CHAN_W-1:0]  finalChan_q;
    logic [ADDR_W-1:0]  addr_q;
    logic [COUNT_W-1:0] count_q;
    logic [WORD_W-1:0]  sample_q;
    logic               auto_q;
    logic               convRun_q;
    logic               intDisable_q;
    logic               pend_q;
    logic               fifoInReady;
    adi_dch_word_t      fifoIn;

    assign hit = ioStrobe && (ioInstr.ioClass == IO_CLASS)
                 && (ioInstr.devCode == CONV_DEV_CODE);
    assign flagOp   = hit && (ioInstr.xfer != XF_SKP);
    assign actStart = flagOp && (ioInstr.func == F_START);
    assign actClear = flagOp && (ioInstr.func == F_CLEAR);
    // Pulse has no meaning without the block engine, so it is ignored then
    assign actPulse = flagOp && (ioInstr.func == F_PULSE) && extendedEnable;

    assign convEnd    = convDone && convRun_q && busy;
    assign wordStored = dchReq && dchAck;
    assign countInc   = count_q + COUNT_ONE;
    assign lastWord   = wordStored && (countInc == COUNT_RST);
    assign setBusy    = actStart || actPulse;

    assign chanNext = (extendedEnable && (channelSel == finalChan_q))
                      ? CHAN_RST : channelSel + CHAN_ONE;

    // ------------------------------------------------------------------
    // Busy, done and mode flags
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy   <= 1'b0;
            auto_q <= 1'b0;
        end else begin
            if (actClear) begin
                busy   <= 1'b0;
                auto_q <= 1'b0;
            end else if (setBusy) begin
                busy   <= 1'b1;
                auto_q <= actPulse;
            end else if ((convEnd && !auto_q) || lastWord) begin
                busy   <= 1'b0;
                auto_q <= 1'b0;
            end
        end
    end

    // A completion landing with a clear still sets done: the event wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done <= 1'b0;
        end else if ((convEnd && !auto_q) || lastWord) begin
            done <= 1'b1;
        end else if (actClear || setBusy) begin
            done <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            intDisable_q <= 1'b0;
            intReq       <= 1'b0;
        end else begin
            if (maskStrobe) begin
                intDisable_q <= accIn[MASK_BIT_IDX];
            end
            intReq <= done && !intDisable_q;
        end
    end

    // ------------------------------------------------------------------
    // Converter control
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            convStart <= 1'b0;
            convRun_q <= 1'b0;
        end else begin
            // Restart only once the previous word left through the channel
            convStart <= setBusy
                         || (wordStored && !lastWord && auto_q && busy && !actClear);
            if (convStart) begin
                convRun_q <= 1'b1;
            end else if (convDone) begin
                convRun_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sample_q <= WORD_RST;
        end else if (convEnd) begin
            sample_q <= convData;
        end
    end

    // ------------------------------------------------------------------
    // Channel registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            channelSel  <= CHAN_RST;
            finalChan_q <= CHAN_RST;
        end else if (hit && (ioInstr.xfer == XF_LD_CHAN)) begin
            channelSel <= accIn[CHAN_W-1:0];
            if (extendedEnable) begin
                finalChan_q <= accIn[WORD_W-1:CHAN_W];
            end
        end else if (convEnd) begin
            channelSel <= chanNext;
        end
    end

    // ------------------------------------------------------------------
    // Block engine: address and count advance together per stored word
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            addr_q  <= ADDR_RST;
            count_q <= COUNT_RST;
        end else begin
            if (hit && extendedEnable && (ioInstr.xfer == XF_LD_ADDR)) begin
                addr_q <= accIn[ADDR_W-1:0];
            end else if (wordStored) begin
                addr_q <= addr_q + ADDR_ONE;
            end
            if (hit && extendedEnable && (ioInstr.xfer == XF_LD_CNT)) begin
                count_q <= accIn[COUNT_W-1:0];
            end else if (wordStored) begin
                count_q <= countInc;
            end
        end
    end

    // Word waits here while the FIFO is full, which holds off the restart
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pend_q <= 1'b0;
        end else if (convEnd && auto_q) begin
            pend_q <= 1'b1;
        end else if (fifoInReady) begin
            pend_q <= 1'b0;
        end
    end

    assign fifoIn.addr = addr_q;
    assign fifoIn.data = sample_q;

    adi_fifo #(
        .WIDTH ($bits(adi_dch_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .inValid  (pend_q),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (dchReq),
        .outReady (dchAck),
        .outData  (dchWord)
    );

    // ------------------------------------------------------------------
    // Read returns and flag tests
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdData    <= WORD_RST;
            rdValid   <= 1'b0;
            rdAcc     <= '0;
            skipTaken <= 1'b0;
        end else begin
            rdValid   <= 1'b0;
            skipTaken <= 1'b0;
            rdAcc     <= ioInstr.accSel;
            if (hit) begin
                case (ioInstr.xfer)
                    XF_RD_CHAN: begin
                        rdValid <= 1'b1;
                        rdData  <= extendedEnable ? {finalChan_q, channelSel}
                                                  : {CHAN_RST, channelSel};
                    end
                    XF_RD_ADDR: begin
                        rdValid <= extendedEnable;
                        rdData  <= {1'b0, addr_q};
                    end
                    XF_RD_SAMP: begin
                        rdValid <= 1'b1;
                        rdData  <= sample_q;
                    end
                    XF_SKP: begin
                        case (ioInstr.func)
                            SK_BUSY_SET:  skipTaken <= busy;
                            SK_BUSY_ZERO: skipTaken <= !busy;
                            SK_DONE_SET:  skipTaken <= done;
                            default:      skipTaken <= !done;
                        endcase
                    end
                    default: begin
                        rdValid <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule : adi_converter_if

// ==== adi_converter_if_properties.sv ====
/*
 * Concurrent checks on the converter IO interface ports.
 * Assumes binding to adi_converter_if; one clock, async high reset.
 */
module adi_converter_if_properties
    import adi_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              reset,
    input wire logic              ioStrobe,
    input wire adi_instr_t        ioInstr,
    input wire logic [WORD_W-1:0] accIn,
    input wire logic              maskStrobe,
    input wire logic              extendedEnable,
    input wire logic              convDone,
    input wire logic [WORD_W-1:0] convData,
    input wire logic              dchAck,
    input wire logic [WORD_W-1:0] rdData,
    input wire logic              rdValid,
    input wire logic [1:0]        rdAcc,
    input wire logic              skipTaken,
    input wire logic              busy,
    input wire logic              done,
    input wire logic              intReq,
    input wire logic              convStart,
    input wire logic [CHAN_W-1:0] channelSel,
    input wire logic              dchReq,
    input wire adi_dch_word_t     dchWord
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    logic              hit;
    logic              maskQ;
    logic [WORD_W-1:0] sampleQ;

    assign hit = ioStrobe && ioInstr.ioClass == IO_CLASS && ioInstr.devCode == CONV_DEV_CODE;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            maskQ <= 1'b0;
        end else if (maskStrobe) begin
            maskQ <= accIn[MASK_BIT_IDX];
        end
    end

    // Only samples taken while a conversion runs count as results
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sampleQ <= WORD_RST;
        end else if (convDone && busy) begin
            sampleQ <= convData;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_start_sets_busy: assert property (
        hit && ioInstr.xfer != XF_SKP && ioInstr.func == F_START && !convDone && !dchAck
        |=> busy && !done && convStart)
        else $error("start did not set busy and launch a conversion");
    a_clear_drops_flags: assert property (
        hit && ioInstr.xfer != XF_SKP && ioInstr.func == F_CLEAR && !convDone && !dchAck
        |=> !busy && !done)
        else $error("clear left a flag set");
    a_foreign_ignored: assert property (
        ioStrobe && !hit && !convDone && !dchAck
        |=> $stable(busy) && $stable(done) && !rdValid && !skipTaken)
        else $error("foreign instruction had an effect");
    a_int_follows_done: assert property (
        done && !maskQ |=> intReq)
        else $error("unmasked done raised no request");
    a_mask_blocks_int: assert property (
        maskQ |=> !intReq)
        else $error("request raised while masked");
    a_basic_complete: assert property (
        busy && convDone && !ioStrobe && !extendedEnable
        |=> !busy && done && channelSel == $past(channelSel) + CHAN_ONE)
        else $error("basic completion wrong");
    a_chan_read_basic: assert property (
        hit && ioInstr.xfer == XF_RD_CHAN && !extendedEnable |=> rdValid
        && rdAcc == $past(ioInstr.accSel) && rdData == {8'h00, $past(channelSel)})
        else $error("basic channel read wrong");
    a_chan_load: assert property (
        hit && ioInstr.xfer == XF_LD_CHAN && !convDone |=> channelSel == $past(accIn[7:0]))
        else $error("channel load wrong");
    a_sample_read: assert property (
        hit && ioInstr.xfer == XF_RD_SAMP && !convDone |=> rdValid && rdData == sampleQ)
        else $error("sample read wrong");
    a_store_advances: assert property (
        dchReq && dchAck |=> convStart || (!busy && done))
        else $error("store neither restarted nor ended the block");
    a_word_held: assert property (
        dchReq && !dchAck |=> dchReq && $stable(dchWord))
        else $error("data channel word dropped or changed");

    c_basic_done: cover property (busy && convDone && !extendedEnable);
    c_store: cover property (dchReq && dchAck);
    c_masked: cover property (maskQ && done);
endmodule : adi_converter_if_properties

bind adi_converter_if adi_converter_if_properties adi_converter_if_properties_inst (.*);

// ==== adi_conv_model.sv ====
/*
 * Converter and data channel model on the far side of the interface.
 * Assumes one conversion per start pulse and one stored word per ack.
 */
module adi_conv_model
    import adi_pkg::*;
#(
    parameter int CONV_LAT = 5,
    parameter int DCH_LAT  = 3
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              convStart,
    input  wire logic [CHAN_W-1:0] channelSel,
    input  wire logic              dchReq,
    input  wire adi_dch_word_t     dchWord,
    output logic                   convDone,
    output logic      [WORD_W-1:0] convData,
    output logic                   dchAck,
    output logic      [7:0]        stores,
    output logic      [ADDR_W-1:0] lastAddr,
    output logic                   wordErr,
    output logic                   seenZero
);
    int                convCnt;
    int                dchCnt;
    logic [WORD_W-1:0] sent;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            convCnt <= 0;
            convDone <= 1'b0;
            convData <= 16'hf000;
            sent <= 16'hf000;
            seenZero <= 1'b0;
        end else begin
            convDone <= 1'b0;
            // Data lines are not held once the done pulse is over
            if (convDone) begin
                convData <= ~convData;
            end
            if (convStart) begin
                convCnt <= CONV_LAT;
                seenZero <= seenZero | (channelSel == CHAN_RST);
            end else if (convCnt == 1) begin
                convDone <= 1'b1;
                convData <= sent + 16'h0001;
                sent <= sent + 16'h0001;
                convCnt <= 0;
            end else if (convCnt > 1) begin
                convCnt <= convCnt - 1;
            end
        end
    end

    // Wait restarts after each ack, so a late request drop is never acked twice
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dchCnt <= 0;
            dchAck <= 1'b0;
            stores <= 8'h00;
            lastAddr <= ADDR_RST;
            wordErr <= 1'b0;
        end else begin
            dchAck <= 1'b0;
            if (!dchReq || dchAck) begin
                dchCnt <= 0;
            end else if (dchCnt == DCH_LAT) begin
                dchAck <= 1'b1;
                stores <= stores + 8'h01;
                lastAddr <= dchWord.addr;
                if (dchWord.data !== sent || (stores != 8'h00 && dchWord.addr !== lastAddr + ADDR_ONE)) begin
                    wordErr <= 1'b1;
                end
            end else begin
                dchCnt <= dchCnt + 1;
            end
        end
    end
endmodule : adi_conv_model

// ==== adi_converter_if_tb.sv ====
/*
 * Self-checking bench for the converter IO interface.
 * Assumes adi_conv_model answers starts and data channel requests.
 */
module adi_converter_if_tb
    import adi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] SKIP_EXP = 4'h6;

    logic core_clk, reset, ioStrobe, maskStrobe, extendedEnable, convDone, dchAck;
    logic rdValid, skipTaken, busy, done, intReq, convStart, dchReq, wordErr, seenZero;
    adi_instr_t        ioInstr;
    logic [WORD_W-1:0] accIn, convData, rdData;
    logic [1:0]        rdAcc;
    logic [CHAN_W-1:0] channelSel;
    adi_dch_word_t     dchWord;
    logic [7:0]        stores;
    logic [ADDR_W-1:0] lastAddr;
    int                fail_count, num_checks;

    adi_converter_if adi_converter_if_inst (.core_clk, .reset, .ioStrobe, .ioInstr, .accIn,
        .maskStrobe, .extendedEnable, .convDone, .convData, .dchAck, .rdData, .rdValid,
        .rdAcc, .skipTaken, .busy, .done, .intReq, .convStart, .channelSel, .dchReq, .dchWord);
    adi_conv_model adi_conv_model_inst (.core_clk, .reset, .convStart, .channelSel, .dchReq,
        .dchWord, .convDone, .convData, .dchAck, .stores, .lastAddr, .wordErr, .seenZero);

    always #20 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One instruction cycle; outputs are settled on return
    task automatic io(input logic [5:0] dev, input logic [2:0] xf, input logic [1:0] fn,
                      input logic [WORD_W-1:0] acc);
        @(posedge core_clk);
        #1;
        ioStrobe = 1'b1;
        ioInstr = '{IO_CLASS, 2'h2, xf, fn, dev};
        accIn = acc;
        @(posedge core_clk);
        #1;
        ioStrobe = 1'b0;
    endtask : io

    task automatic rd(input logic [2:0] xf, input logic [WORD_W-1:0] exp);
        io(CONV_DEV_CODE, xf, F_NONE, 16'h0000);
        chk({rdValid, rdAcc}, 16'h0006);
        chk(rdData, exp);
    endtask : rd
    task automatic set_mask(input logic [WORD_W-1:0] acc);
        @(posedge core_clk);
        #1;
        maskStrobe = 1'b1;
        accIn = acc;
        @(posedge core_clk);
        #1;
        maskStrobe = 1'b0;
    endtask : set_mask
    task automatic wait_idle;
        int n = 0;
        while (busy !== 1'b0 && n < 500) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            finish_test();
        end
    endtask : wait_idle

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        ioStrobe = 1'b0;
        ioInstr = '0;
        accIn = '0;
        maskStrobe = 1'b0;
        extendedEnable = 1'b0;
        fail_count = 0;
        num_checks = 0;
        repeat (3) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk({busy, done, intReq, dchReq, channelSel}, 16'h0000);
        io(6'h12, XF_LD_CHAN, F_START, 16'h0055);
        chk({busy, channelSel}, 16'h0000);
        io(CONV_DEV_CODE, XF_NIO, F_PULSE, 16'h0000);
        chk(busy, 1'b0);
        io(CONV_DEV_CODE, XF_LD_CHAN, F_START, 16'hab05);
        chk({busy, done, convStart, channelSel}, {3'b101, 8'h05});
        wait_idle();
        chk({done, channelSel}, {1'b1, 8'h06});
        @(posedge core_clk);
        #1;
        chk(intReq, 1'b1);
        rd(XF_RD_SAMP, 16'hf001);
        rd(XF_RD_CHAN, 16'h0006);
        for (int k = 0; k < 4; k++) begin
            io(CONV_DEV_CODE, XF_SKP, k[1:0], 16'h0000);
            chk(skipTaken, SKIP_EXP[k]);
        end
        set_mask(16'h0080);
        @(posedge core_clk);
        #1;
        chk(intReq, 1'b0);
        set_mask(16'h0000);
        io(CONV_DEV_CODE, XF_NIO, F_CLEAR, 16'h0000);
        chk({busy, done}, 2'b00);
        io(CONV_DEV_CODE, XF_NIO, F_START, 16'h0000);
        io(CONV_DEV_CODE, XF_NIO, F_CLEAR, 16'h0000);
        chk({busy, done}, 2'b00);
        repeat (12) @(posedge core_clk);
        #1 extendedEnable = 1'b1;
        io(CONV_DEV_CODE, XF_LD_CHAN, F_NONE, 16'h0301);
        rd(XF_RD_CHAN, 16'h0301);
        io(CONV_DEV_CODE, XF_LD_ADDR, F_NONE, 16'h8100);
        rd(XF_RD_ADDR, 16'h0100);
        io(CONV_DEV_CODE, XF_LD_CNT, F_NONE, 16'hfffc);
        io(CONV_DEV_CODE, XF_NIO, F_PULSE, 16'h0000);
        chk({busy, done, convStart}, 3'b101);
        wait_idle();
        chk({done, stores}, {1'b1, 8'h04});
        chk(lastAddr, 15'h0103);
        chk({wordErr, seenZero}, 2'b01);
        rd(XF_RD_ADDR, 16'h0104);
        chk(channelSel <= 8'h03, 1'b1);
        finish_test();
    end
endmodule : adi_converter_if_tb
